// [shared/rd_pkg.sv]
package rd_pkg;
	localparam int SYS_CLK_HZ  = 50_000_000;
	localparam int RATE_NOM_HZ = 8000;
	localparam int RATE_MAX_HZ = 16000;
	localparam int TW          = 13;

	localparam int DEB_MS          = 32;
	localparam int PULSE_PERIOD_MS = 100;
	localparam int BREAK_MS        = 60;
	localparam int MAKE_MS         = PULSE_PERIOD_MS - BREAK_MS;
	localparam int PULSE_IDP_MS    = 800;
	localparam int TONE_ON_MS      = 98;
	localparam int TONE_OFF_MS     = 102;
	localparam int PRE_PULSE_MS    = 172;
	localparam int PRE_TONE_MS     = 132;
	localparam int ACK_HALF_MS     = 1;
	localparam int ACK_MAX_MS      = 30;

	// Rate oscillator ticks at the nominal rate
	localparam logic [TW-1:0] DEB_TICKS       = TW'((DEB_MS * RATE_NOM_HZ + 999) / 1000);
	localparam logic [TW-1:0] BREAK_TICKS     = TW'((BREAK_MS * RATE_NOM_HZ) / 1000);
	localparam logic [TW-1:0] MAKE_TICKS      = TW'((MAKE_MS * RATE_NOM_HZ) / 1000);
	localparam logic [TW-1:0] IDP_TICKS       = TW'((PULSE_IDP_MS * RATE_NOM_HZ) / 1000);
	localparam logic [TW-1:0] TONE_ON_TICKS   = TW'((TONE_ON_MS * RATE_NOM_HZ) / 1000);
	localparam logic [TW-1:0] TONE_OFF_TICKS  = TW'((TONE_OFF_MS * RATE_NOM_HZ) / 1000);
	localparam logic [TW-1:0] PRE_PULSE_TICKS = TW'((PRE_PULSE_MS * RATE_NOM_HZ) / 1000);
	localparam logic [TW-1:0] PRE_TONE_TICKS  = TW'((PRE_TONE_MS * RATE_NOM_HZ) / 1000);

	// System clock cycles for the acknowledge tone
	localparam int ACK_HALF_CYC_DEF = ACK_HALF_MS * (SYS_CLK_HZ / 1000);
	localparam int ACK_MAX_CYC_DEF  = ACK_MAX_MS * (SYS_CLK_HZ / 1000);

	localparam int NROW        = 4;
	localparam int NCOL        = 3;
	localparam int NUM_LOC_DEF = 10;
	localparam int NUM_DIG_DEF = 16;

	// Key code is {row index, column index}
	localparam logic [3:0] KEY_STAR = 4'hc;
	localparam logic [3:0] KEY_ZERO = 4'hd;
	localparam logic [3:0] KEY_HASH = 4'he;
	localparam logic [3:0] ZERO_PULSES = 4'ha;

	typedef enum logic [4:0] {
		KS_IDLE  = 5'h01,
		KS_SCAN  = 5'h02,
		KS_DEB   = 5'h04,
		KS_CHECK = 5'h08,
		KS_REL   = 5'h10
	} rd_key_e;

	typedef enum logic [6:0] {
		DS_IDLE  = 7'h01,
		DS_PRE   = 7'h02,
		DS_BREAK = 7'h04,
		DS_MAKE  = 7'h08,
		DS_IDP   = 7'h10,
		DS_TON   = 7'h20,
		DS_TOFF  = 7'h40
	} rd_dial_e;
endpackage

// [hdl/rd_dialer.sv]
`timescale 1ns/10ps
module rd_dialer #(
	parameter int NUM_LOC      = rd_pkg::NUM_LOC_DEF,
	parameter int NUM_DIG      = rd_pkg::NUM_DIG_DEF,
	parameter int ACK_HALF_CYC = rd_pkg::ACK_HALF_CYC_DEF,
	parameter int ACK_MAX_CYC  = rd_pkg::ACK_MAX_CYC_DEF
) (
	// Clock and reset
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	// Line side straps
	input  wire logic                    hook_switch_input,
	input  wire logic                    mode_select,
	// Rate oscillator
	input  wire logic                    rate_osc_in,
	output logic                         rate_osc_enable,
	// Keypad rows, bit 0 is keypad_row_one
	input  wire logic [rd_pkg::NROW-1:0] keypad_row_in,
	output logic      [rd_pkg::NROW-1:0] keypad_row_out,
	output logic      [rd_pkg::NROW-1:0] keypad_row_oe_n,
	// Keypad columns, bit 0 is keypad_column_one
	input  wire logic [rd_pkg::NCOL-1:0] keypad_column_in,
	output logic      [rd_pkg::NCOL-1:0] keypad_column_out,
	output logic      [rd_pkg::NCOL-1:0] keypad_column_oe_n,
	// Acknowledge tone and chip disable pin
	input  wire logic                    ack_tone_in,
	output logic                         ack_tone_out,
	output logic                         ack_tone_oe_n,
	// Signalling
	output logic                         crystal_run,
	output logic      [1:0]              tone_row_sel,
	output logic      [1:0]              tone_col_sel,
	output logic                         pulse_out,
	output logic                         pulse_oe_n,
	output logic                         mute_out,
	output logic                         mute_oe_n
);
	import rd_pkg::*;

	localparam int SW = NROW + NCOL + 4;
	// Pins reset to their idle levels so no false edge or wake follows reset
	localparam logic [SW-1:0] SYNC_IDLE = {4'hc, {NROW{1'b1}}, {NCOL{1'b0}}};
	localparam int AW = $clog2(ACK_MAX_CYC + 1);
	localparam int HW = $clog2(ACK_HALF_CYC + 1);

	generate
		if (NUM_LOC < 2 || NUM_LOC > 10 || NUM_DIG < 1 || NUM_DIG > 16 ||
		    ACK_HALF_CYC < 1 || ACK_MAX_CYC < ACK_HALF_CYC) begin : g_bad_param
			$error("rd_dialer: unsupported parameter values");
		end
	endgenerate

	function automatic logic [1:0] first_set(input logic [3:0] v);
		first_set = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 2'(i);
			end
		end
	endfunction

	// Pulses per key; also the location a digit key addresses
	function automatic logic [3:0] pulse_count(input logic [3:0] c);
		if (c[3:2] != 2'h3) begin
			pulse_count = 4'(c[3:2] * 3 + c[1:0] + 1);
		end else if (c == KEY_ZERO) begin
			pulse_count = ZERO_PULSES;
		end else begin
			pulse_count = 4'h0;
		end
	endfunction

	// Reset release
	logic [1:0] rst_sr_reg;
	logic       rst_sync_n;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sr_reg <= 2'h0;
		end else begin
			rst_sr_reg <= {rst_sr_reg[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sr_reg[1];

	// Pin synchronisers
	logic [SW-1:0]   sync1_reg;
	logic [SW-1:0]   sync2_reg;
	logic            hook_s;
	logic            mode_s;
	logic            rate_s;
	logic            ack_s;
	logic [NROW-1:0] rows_s;
	logic [NCOL-1:0] cols_s;
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sync1_reg <= SYNC_IDLE;
			sync2_reg <= SYNC_IDLE;
		end else begin
			sync1_reg <= {hook_switch_input, mode_select, rate_osc_in, ack_tone_in,
			              keypad_row_in, keypad_column_in};
			sync2_reg <= sync1_reg;
		end
	end
	assign {hook_s, mode_s, rate_s, ack_s, rows_s, cols_s} = sync2_reg;

	// Edge detection and control reinitialisation
	logic       rate_prev_reg;
	logic       hook_prev_reg;
	logic [2:0] ack_rel_reg;
	logic [2:0] ack_rel_next;
	logic       ack_oe_n_reg;
	logic       tick;
	logic       hook_edge;
	logic       chip_dis;
	logic       init;
	always_comb begin
		ack_rel_next = {ack_rel_reg[1:0], ack_oe_n_reg};
		tick         = rate_s & ~rate_prev_reg;
		hook_edge    = hook_s ^ hook_prev_reg;
		chip_dis     = ack_s & (&ack_rel_reg);
		init         = hook_edge | chip_dis;
	end

	// Key entry and number memory
	rd_key_e         ks_reg, ks_next;
	logic [TW-1:0]   kt_reg, kt_next;
	logic            phase_reg, phase_next;
	logic [NROW-1:0] row_seen_reg, row_seen_next;
	logic [NCOL-1:0] col_seen_reg, col_seen_next;
	logic            mod_reg, mod_next;
	logic            fresh_reg, fresh_next;
	logic            restart_reg, restart_next;
	logic            stored_reg, stored_next;
	logic [NROW-1:0] row_oe_n_reg, row_oe_n_next;
	logic [NCOL-1:0] col_oe_n_reg, col_oe_n_next;
	logic [3:0]      mem_reg [NUM_LOC][NUM_DIG];
	logic [3:0]      mem_next [NUM_LOC][NUM_DIG];
	logic [4:0]      len_reg [NUM_LOC];
	logic [4:0]      len_next [NUM_LOC];
	logic [3:0]      code;
	logic [3:0]      loc;
	logic            key_ok;
	logic            none_seen;
	rd_dial_e        ds_reg;

	always_comb begin
		ks_next       = ks_reg;
		kt_next       = kt_reg;
		phase_next    = phase_reg;
		row_seen_next = row_seen_reg;
		col_seen_next = col_seen_reg;
		mod_next      = mod_reg;
		fresh_next    = fresh_reg;
		mem_next      = mem_reg;
		len_next      = len_reg;
		restart_next  = 1'b0;
		stored_next   = 1'b0;
		code          = {first_set(row_seen_reg), first_set({1'b0, col_seen_reg})};
		loc           = pulse_count(code);
		key_ok        = $onehot(row_seen_reg) && $onehot(col_seen_reg);
		none_seen     = (row_seen_reg == '0) && (col_seen_reg == '0);
		if (tick && ks_reg != KS_IDLE) begin
			phase_next = ~phase_reg;
			if (!phase_reg) begin
				row_seen_next = ~rows_s;
			end else begin
				col_seen_next = ~cols_s;
			end
		end
		case (ks_reg)
			KS_IDLE: begin
				if (rows_s != '1 || cols_s != '0) begin
					ks_next       = KS_SCAN;
					row_seen_next = '0;
					col_seen_next = '0;
				end
			end
			KS_SCAN: begin
				if (tick && key_ok) begin
					ks_next = KS_DEB;
					kt_next = '0;
				end else if (tick && phase_reg && none_seen) begin
					ks_next    = KS_IDLE;
					phase_next = 1'b0;
				end
			end
			KS_DEB: begin
				if (tick) begin
					kt_next = kt_reg + 1'b1;
					if (kt_reg == DEB_TICKS - 1'b1) begin
						ks_next       = KS_CHECK;
						kt_next       = '0;
						row_seen_next = '0;
						col_seen_next = '0;
					end
				end
			end
			KS_CHECK: begin
				if (tick) begin
					kt_next = kt_reg + 1'b1;
				end else if (kt_reg == TW'(2)) begin
					if (key_ok) begin
						ks_next     = KS_REL;
						stored_next = 1'b1;
						if (mod_reg) begin
							mod_next = 1'b0;
							if (code == KEY_STAR || code == KEY_HASH) begin
								stored_next = 1'b1;
							end else if (32'(loc) < NUM_LOC && hook_s) begin
								mem_next[loc] = mem_reg[0];
								len_next[loc] = len_reg[0];
							end else if (32'(loc) < NUM_LOC && ds_reg == DS_IDLE) begin
								mem_next[0]  = mem_reg[loc];
								len_next[0]  = len_reg[loc];
								restart_next = 1'b1;
								fresh_next   = 1'b0;
							end
						end else if (code == KEY_STAR) begin
							mod_next = 1'b1;
						end
						if ((mod_reg && (code == KEY_STAR || code == KEY_HASH)) ||
						    (!mod_reg && code != KEY_STAR && code != KEY_HASH)) begin
							if (fresh_reg) begin
								mem_next[0][0] = code;
								len_next[0]    = 5'h01;
								fresh_next     = 1'b0;
								restart_next   = 1'b1;
							end else if (32'(len_reg[0]) < NUM_DIG) begin
								mem_next[0][len_reg[0][3:0]] = code;
								len_next[0]  = len_reg[0] + 1'b1;
							end
						end
					end else begin
						ks_next = KS_SCAN;
					end
				end
			end
			KS_REL: begin
				if (tick && phase_reg && none_seen) begin
					ks_next    = KS_IDLE;
					phase_next = 1'b0;
				end
			end
			default: ks_next = KS_IDLE;
		endcase
		if (init) begin
			ks_next       = KS_IDLE;
			kt_next       = '0;
			phase_next    = 1'b0;
			row_seen_next = '0;
			col_seen_next = '0;
			mod_next      = 1'b0;
			stored_next   = 1'b0;
			restart_next  = 1'b0;
			mem_next      = mem_reg;
			len_next      = len_reg;
			if (hook_edge) begin
				fresh_next = 1'b1;
				if (mod_reg) begin
					len_next[0] = 5'h00;
				end
			end
		end
		// Standby: rows released high, columns driven low
		row_oe_n_next = (phase_next && !chip_dis) ? '0 : '1;
		col_oe_n_next = (!phase_next && !chip_dis) ? '0 : '1;
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ks_reg       <= KS_IDLE;
			kt_reg       <= '0;
			phase_reg    <= 1'b0;
			row_seen_reg <= '0;
			col_seen_reg <= '0;
			mod_reg      <= 1'b0;
			fresh_reg    <= 1'b1;
			restart_reg  <= 1'b0;
			stored_reg   <= 1'b0;
			row_oe_n_reg <= '1;
			col_oe_n_reg <= '0;
			mem_reg      <= '{default: '{default: 4'h0}};
			len_reg      <= '{default: 5'h00};
		end else begin
			ks_reg       <= ks_next;
			kt_reg       <= kt_next;
			phase_reg    <= phase_next;
			row_seen_reg <= row_seen_next;
			col_seen_reg <= col_seen_next;
			mod_reg      <= mod_next;
			fresh_reg    <= fresh_next;
			restart_reg  <= restart_next;
			stored_reg   <= stored_next;
			row_oe_n_reg <= row_oe_n_next;
			col_oe_n_reg <= col_oe_n_next;
			mem_reg      <= mem_next;
			len_reg      <= len_next;
		end
	end

	// Dialing sequencer
	rd_dial_e      ds_next;
	logic [TW-1:0] dt_reg, dt_next;
	logic [3:0]    pc_reg, pc_next;
	logic [4:0]    ptr_reg, ptr_next;
	logic [1:0]    trow_reg, trow_next;
	logic [1:0]    tcol_reg, tcol_next;
	logic          launch;
	logic          pending;
	logic [3:0]    digit;
	always_comb begin
		ds_next   = ds_reg;
		dt_next   = dt_reg;
		pc_next   = pc_reg;
		ptr_next  = ptr_reg;
		trow_next = trow_reg;
		tcol_next = tcol_reg;
		launch    = 1'b0;
		digit     = mem_reg[0][ptr_reg[3:0]];
		pending   = !hook_s && (ptr_reg < len_reg[0]);
		if (tick) begin
			dt_next = dt_reg + 1'b1;
		end
		case (ds_reg)
			DS_IDLE: begin
				dt_next = '0;
				if (pending) begin
					ds_next = DS_PRE;
				end
			end
			DS_PRE: begin
				if (tick && dt_reg == (mode_s ? PRE_TONE_TICKS : PRE_PULSE_TICKS) - 1'b1) begin
					launch = 1'b1;
				end
			end
			DS_BREAK: begin
				if (tick && dt_reg == BREAK_TICKS - 1'b1) begin
					ds_next = DS_MAKE;
					dt_next = '0;
				end
			end
			DS_MAKE: begin
				if (tick && dt_reg == MAKE_TICKS - 1'b1) begin
					dt_next = '0;
					pc_next = pc_reg - 1'b1;
					ds_next = (pc_reg == 4'h1) ? DS_IDP : DS_BREAK;
					if (pc_reg == 4'h1) begin
						ptr_next = ptr_reg + 1'b1;
					end
				end
			end
			DS_IDP: begin
				if (tick && dt_reg == IDP_TICKS - 1'b1) begin
					launch = 1'b1;
				end
			end
			DS_TON: begin
				if (tick && dt_reg == TONE_ON_TICKS - 1'b1) begin
					ds_next  = DS_TOFF;
					dt_next  = '0;
					ptr_next = ptr_reg + 1'b1;
				end
			end
			DS_TOFF: begin
				if (tick && dt_reg == TONE_OFF_TICKS - 1'b1) begin
					launch = 1'b1;
				end
			end
			default: ds_next = DS_IDLE;
		endcase
		if (launch) begin
			dt_next = '0;
			if (!pending) begin
				ds_next = DS_IDLE;
			end else if (mode_s) begin
				ds_next   = DS_TON;
				trow_next = digit[3:2];
				tcol_next = digit[1:0];
			end else if (pulse_count(digit) == 4'h0) begin
				ds_next  = DS_IDP;
				ptr_next = ptr_reg + 1'b1;
			end else begin
				ds_next = DS_BREAK;
				pc_next = pulse_count(digit);
			end
		end
		if (restart_reg) begin
			ptr_next = 5'h00;
		end
		if (init) begin
			ds_next  = DS_IDLE;
			dt_next  = '0;
			pc_next  = 4'h0;
			ptr_next = len_reg[0];
		end
	end

	logic rate_en_reg;
	logic zero_reg;
	logic crystal_reg;
	logic pulse_oe_n_reg;
	logic mute_oe_n_reg;
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ds_reg         <= DS_IDLE;
			dt_reg         <= '0;
			pc_reg         <= 4'h0;
			ptr_reg        <= 5'h00;
			trow_reg       <= 2'h0;
			tcol_reg       <= 2'h0;
			crystal_reg    <= 1'b0;
			pulse_oe_n_reg <= 1'b1;
			mute_oe_n_reg  <= 1'b1;
			rate_en_reg    <= 1'b0;
			zero_reg       <= 1'b0;
			rate_prev_reg  <= 1'b0;
			hook_prev_reg  <= 1'b1;
			ack_rel_reg    <= 3'h0;
		end else begin
			ds_reg         <= ds_next;
			dt_reg         <= dt_next;
			pc_reg         <= pc_next;
			ptr_reg        <= ptr_next;
			trow_reg       <= trow_next;
			tcol_reg       <= tcol_next;
			crystal_reg    <= (ds_next == DS_TON);
			pulse_oe_n_reg <= (ds_next != DS_BREAK);
			mute_oe_n_reg  <= (ds_next == DS_IDLE);
			rate_en_reg    <= (ks_next != KS_IDLE) || (ds_next != DS_IDLE);
			zero_reg       <= 1'b0;
			rate_prev_reg  <= rate_s;
			hook_prev_reg  <= hook_s;
			ack_rel_reg    <= ack_rel_next;
		end
	end

	// Acknowledge tone generator
	logic [AW-1:0] ack_cnt_reg, ack_cnt_next;
	logic [HW-1:0] ack_half_reg, ack_half_next;
	logic          ack_oe_n_next;
	logic          ack_lvl_reg, ack_lvl_next;
	always_comb begin
		ack_cnt_next  = ack_cnt_reg;
		ack_half_next = ack_half_reg;
		ack_oe_n_next = ack_oe_n_reg;
		ack_lvl_next  = ack_lvl_reg;
		if (stored_reg && (!mode_s || hook_s)) begin
			ack_oe_n_next = 1'b0;
			ack_cnt_next  = '0;
			ack_half_next = '0;
			ack_lvl_next  = 1'b1;
		end else if (!ack_oe_n_reg) begin
			ack_cnt_next = ack_cnt_reg + 1'b1;
			if (ack_cnt_reg == AW'(ACK_MAX_CYC - 1) || ks_reg != KS_REL) begin
				ack_oe_n_next = 1'b1;
			end
			if (ack_half_reg == HW'(ACK_HALF_CYC - 1)) begin
				ack_half_next = '0;
				ack_lvl_next  = ~ack_lvl_reg;
			end else begin
				ack_half_next = ack_half_reg + 1'b1;
			end
		end
		if (init) begin
			ack_oe_n_next = 1'b1;
			ack_lvl_next  = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ack_cnt_reg  <= '0;
			ack_half_reg <= '0;
			ack_oe_n_reg <= 1'b1;
			ack_lvl_reg  <= 1'b0;
		end else begin
			ack_cnt_reg  <= ack_cnt_next;
			ack_half_reg <= ack_half_next;
			ack_oe_n_reg <= ack_oe_n_next;
			ack_lvl_reg  <= ack_lvl_next;
		end
	end

	assign rate_osc_enable    = rate_en_reg;
	assign keypad_row_out     = {NROW{zero_reg}};
	assign keypad_row_oe_n    = row_oe_n_reg;
	assign keypad_column_out  = {NCOL{zero_reg}};
	assign keypad_column_oe_n = col_oe_n_reg;
	assign ack_tone_out       = ack_lvl_reg;
	assign ack_tone_oe_n      = ack_oe_n_reg;
	assign crystal_run        = crystal_reg;
	assign tone_row_sel       = trow_reg;
	assign tone_col_sel       = tcol_reg;
	assign pulse_out          = zero_reg;
	assign pulse_oe_n         = pulse_oe_n_reg;
	assign mute_out           = zero_reg;
	assign mute_oe_n          = mute_oe_n_reg;
endmodule

// [verif/rd_dialer_asserts.sv]
`timescale 1ns/10ps
module rd_dialer_asserts
	import rd_pkg::*;
#(
	parameter int ACK_MAX_CYC = ACK_MAX_CYC_DEF
) (
	// Clock, reset and straps
	input wire logic            sys_clk,
	input wire logic            rst_n,
	input wire logic            hook_switch_input,
	input wire logic            ack_tone_in,
	// Keypad
	input wire logic            rate_osc_enable,
	input wire logic [NROW-1:0] keypad_row_in,
	input wire logic [NROW-1:0] keypad_row_oe_n,
	input wire logic [NCOL-1:0] keypad_column_oe_n,
	// Signalling
	input wire logic            ack_tone_oe_n,
	input wire logic            crystal_run,
	input wire logic [1:0]      tone_row_sel,
	input wire logic            pulse_oe_n,
	input wire logic            mute_oe_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	logic [3:0]  hook_hi_reg;
	logic [3:0]  hook_hi_next;
	logic [3:0]  ack_hi_reg;
	logic [3:0]  ack_hi_next;
	logic [3:0]  ack_lo_reg;
	logic [3:0]  ack_lo_next;
	logic [15:0] ack_len_reg;
	logic [15:0] ack_len_next;

	// Run lengths of pin levels; the 4-bit ones saturate, ack_len_reg does not
	always_comb begin
		hook_hi_next = hook_switch_input ? hook_hi_reg + {3'h0, hook_hi_reg != 4'hf} : 4'h0;
		ack_hi_next = ack_tone_in ? ack_hi_reg + {3'h0, ack_hi_reg != 4'hf} : 4'h0;
		ack_lo_next = !ack_tone_in ? ack_lo_reg + {3'h0, ack_lo_reg != 4'hf} : 4'h0;
		ack_len_next = !ack_tone_oe_n ? ack_len_reg + 16'h1 : 16'h0;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hook_hi_reg <= 4'h0;
			ack_hi_reg <= 4'h0;
			ack_lo_reg <= 4'h0;
			ack_len_reg <= 16'h0;
		end else begin
			hook_hi_reg <= hook_hi_next;
			ack_hi_reg <= ack_hi_next;
			ack_lo_reg <= ack_lo_next;
			ack_len_reg <= ack_len_next;
		end
	end

	a_standby_levels: assert property (!rate_osc_enable && !$past(rate_osc_enable)
		&& ack_lo_reg == 4'hf |-> keypad_row_oe_n == 4'hf && keypad_column_oe_n == 3'h0)
		else $error("keypad pins not at standby levels");
	a_key_wakes_osc: assert property (!rate_osc_enable && keypad_row_oe_n == 4'hf
		&& keypad_row_in != 4'hf && ack_lo_reg == 4'hf |-> ##[1:8] rate_osc_enable)
		else $error("closure did not start the rate oscillator");
	a_busy_osc_on: assert property (!mute_oe_n && !$past(mute_oe_n) |-> rate_osc_enable)
		else $error("dialing without the rate oscillator");
	a_crystal_tone_only: assert property (crystal_run |-> !mute_oe_n && pulse_oe_n)
		else $error("crystal running outside a tone");
	a_break_muted: assert property (!pulse_oe_n |-> !mute_oe_n && !crystal_run)
		else $error("line break without mute");
	a_break_holds: assert property ($fell(pulse_oe_n) |-> !pulse_oe_n [*8])
		else $error("line break too short");
	a_tone_steady: assert property ($rose(crystal_run) |=>
		(crystal_run && $stable(tone_row_sel)) [*8])
		else $error("tone burst not steady");
	a_onhook_silent: assert property (hook_hi_reg == 4'hf |-> mute_oe_n && pulse_oe_n)
		else $error("signalling while on-hook");
	a_disable_quiet: assert property (ack_hi_reg == 4'hf && ack_tone_oe_n
		|-> !rate_osc_enable && mute_oe_n)
		else $error("activity while chip disabled");
	a_ack_bounded: assert property (ack_len_reg <= 16'(ACK_MAX_CYC + 2))
		else $error("acknowledge tone too long");

	c_tone: cover property ($rose(crystal_run));
	c_break: cover property ($fell(pulse_oe_n));
	c_ack: cover property ($fell(ack_tone_oe_n));
endmodule

bind rd_dialer rd_dialer_asserts #(.ACK_MAX_CYC(ACK_MAX_CYC)) u_rd_dialer_asserts (
	.sys_clk(sys_clk), .rst_n(rst_n), .hook_switch_input(hook_switch_input),
	.ack_tone_in(ack_tone_in), .rate_osc_enable(rate_osc_enable),
	.keypad_row_in(keypad_row_in), .keypad_row_oe_n(keypad_row_oe_n),
	.keypad_column_oe_n(keypad_column_oe_n), .ack_tone_oe_n(ack_tone_oe_n),
	.crystal_run(crystal_run), .tone_row_sel(tone_row_sel), .pulse_oe_n(pulse_oe_n),
	.mute_oe_n(mute_oe_n)
);

// [verif/rd_keypad_model.sv]
`timescale 1ns/10ps
module rd_keypad_model (
	// Clock and bench controls
	input  wire logic        sys_clk,
	input  wire logic [11:0] key_closed,
	input  wire logic        ack_strap,
	// Dialer pins
	input  wire logic        rate_osc_enable,
	output logic             rate_osc_in,
	input  wire logic [3:0]  keypad_row_out,
	input  wire logic [3:0]  keypad_row_oe_n,
	output logic      [3:0]  keypad_row_in,
	input  wire logic [2:0]  keypad_column_out,
	input  wire logic [2:0]  keypad_column_oe_n,
	output logic      [2:0]  keypad_column_in,
	input  wire logic        ack_tone_out,
	input  wire logic        ack_tone_oe_n,
	output logic             ack_tone_in
);
	logic [3:0] row_low;
	logic [2:0] col_low;
	logic [1:0] osc_reg;
	logic [1:0] osc_next;

	// A closed contact joins its row and column; released nets are pulled high
	always_comb begin
		row_low = ~keypad_row_oe_n & ~keypad_row_out;
		col_low = ~keypad_column_oe_n & ~keypad_column_out;
		keypad_row_in = ~row_low;
		keypad_column_in = ~col_low;
		for (int r = 0; r < 4; r++) begin
			for (int c = 0; c < 3; c++) begin
				if (key_closed[r*3+c] && (row_low[r] || col_low[c])) begin
					keypad_row_in[r] = 1'b0;
					keypad_column_in[c] = 1'b0;
				end
			end
		end
		ack_tone_in = ack_tone_oe_n ? ack_strap : ack_tone_out;
		// RC oscillator stands low unless enabled, one rise every 4 cycles
		osc_next = rate_osc_enable ? osc_reg + 2'h1 : 2'h0;
		rate_osc_in = osc_reg[1];
	end

	always_ff @(posedge sys_clk) begin
		osc_reg <= osc_next;
	end
endmodule

// [verif/repertory_dialer_keypad_control_tb.sv]
`timescale 1ns/10ps
module repertory_dialer_keypad_control_tb;
	import rd_pkg::*;
	localparam int TCK = 4;
	logic        sys_clk;
	logic        rst_n;
	logic        hook_switch_input;
	logic        mode_select;
	logic        ack_strap;
	logic [11:0] keys;
	logic        rate_osc_in;
	logic        rate_osc_enable;
	logic [3:0]  row_in;
	logic [3:0]  row_out;
	logic [3:0]  row_oe_n;
	logic [2:0]  col_in;
	logic [2:0]  col_out;
	logic [2:0]  col_oe_n;
	logic        ack_in;
	logic        ack_out;
	logic        ack_oe_n;
	logic        crystal_run;
	logic [1:0]  tone_row_sel;
	logic [1:0]  tone_col_sel;
	logic        pulse_oe_n;
	logic        mute_oe_n;
	logic        pulse_out;
	logic        mute_out;
	logic [15:0] idle_pins;
	logic        cr_d;
	logic        pb_d;
	logic        ak_d;
	logic        mu_d;
	logic [7:0]  exp_q[$];
	logic [31:0] lfsr_reg;
	int          bad_count;
	int          checks_done;
	int          cyc;
	int          pre_t;
	int          pre_exp;
	int          cr_n;
	int          pb_n;

	assign idle_pins = {4'h0, row_oe_n, 1'b0, col_oe_n, pulse_oe_n, mute_oe_n, crystal_run,
		rate_osc_enable};

	rd_dialer #(.ACK_HALF_CYC(4), .ACK_MAX_CYC(40)) u_rd_dialer (
		.sys_clk(sys_clk), .rst_n(rst_n), .hook_switch_input(hook_switch_input),
		.mode_select(mode_select), .rate_osc_in(rate_osc_in),
		.rate_osc_enable(rate_osc_enable), .keypad_row_in(row_in), .keypad_row_out(row_out),
		.keypad_row_oe_n(row_oe_n), .keypad_column_in(col_in), .keypad_column_out(col_out),
		.keypad_column_oe_n(col_oe_n), .ack_tone_in(ack_in), .ack_tone_out(ack_out),
		.ack_tone_oe_n(ack_oe_n), .crystal_run(crystal_run), .tone_row_sel(tone_row_sel),
		.tone_col_sel(tone_col_sel), .pulse_out(pulse_out), .pulse_oe_n(pulse_oe_n),
		.mute_out(mute_out), .mute_oe_n(mute_oe_n)
	);

	rd_keypad_model u_rd_keypad_model (
		.sys_clk(sys_clk), .key_closed(keys), .ack_strap(ack_strap),
		.rate_osc_enable(rate_osc_enable), .rate_osc_in(rate_osc_in),
		.keypad_row_out(row_out), .keypad_row_oe_n(row_oe_n), .keypad_row_in(row_in),
		.keypad_column_out(col_out), .keypad_column_oe_n(col_oe_n),
		.keypad_column_in(col_in), .ack_tone_out(ack_out), .ack_tone_oe_n(ack_oe_n),
		.ack_tone_in(ack_in)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [11:0] kmask(input logic [1:0] r, input logic [1:0] c);
		return 12'h001 << (r * 3 + c);
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic note(input logic [7:0] seen);
		check({8'h0, seen}, exp_q.size() > 0 ? {8'h0, exp_q.pop_front()} : 16'hxxxx);
	endtask

	task automatic press(input logic [11:0] m, input int hold);
		@(posedge sys_clk);
		keys <= m;
		repeat (hold * TCK) @(posedge sys_clk);
		keys <= 12'h000;
		repeat (40 * TCK) @(posedge sys_clk);
	endtask

	task automatic settle(input int lim, input logic idle);
		for (int i = 0; i < lim && (exp_q.size() > 0 || (idle && mute_oe_n !== 1'b1)); i++)
			@(posedge sys_clk);
		check(16'(exp_q.size()), 16'h0);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Watches the pins and matches each event against the oldest note
	always @(posedge sys_clk) begin
		cyc++;
		if (rst_n === 1'b1) begin
			if (!mute_oe_n && mu_d) begin
				pre_t = cyc;
				check(16'({pulse_out, mute_out}), 16'h0);
			end
			if (pre_t > 0 && ((crystal_run && !cr_d) || (!pulse_oe_n && pb_d))) begin
				check(16'(cyc - pre_t > pre_exp - 8 && cyc - pre_t < pre_exp + 8), 16'h1);
				pre_t = 0;
			end
			if (crystal_run && !cr_d)
				note({4'h1, tone_row_sel, tone_col_sel});
			if (!pulse_oe_n && pb_d)
				note(8'h80);
			if (!ack_oe_n && ak_d)
				note({1'b0, ack_out, 6'h00});
			if (!crystal_run && cr_d)
				check(16'(cr_n), 16'(TONE_ON_TICKS * TCK));
			if (pulse_oe_n && !pb_d)
				check(16'(pb_n), 16'(BREAK_TICKS * TCK));
		end
		cr_n = crystal_run ? cr_n + 1 : 0;
		pb_n = pulse_oe_n ? 0 : pb_n + 1;
		cr_d = crystal_run;
		pb_d = pulse_oe_n;
		ak_d = ack_oe_n;
		mu_d = mute_oe_n;
	end

	initial begin
		repeat (100000) @(posedge sys_clk);
		bad_count++;
		wrap_up();
	end

	initial begin
		logic [1:0] r;
		logic [1:0] c;
		rst_n = 1'b0;
		hook_switch_input = 1'b0;
		mode_select = 1'b1; // Strapped firmly to a rail
		ack_strap = 1'b0;
		keys = 12'h000;
		lfsr_reg = 32'hfc675008;
		repeat (3) @(posedge sys_clk);
		check(idle_pins, 16'h0f0c);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		// Tone mode off-hook: a double closure, then two quick digits
		pre_exp = PRE_TONE_TICKS * TCK;
		press(12'h003, 300);
		for (int i = 0; i < 2; i++) begin
			lfsr_reg = lfsr(lfsr_reg);
			r = 2'(lfsr_reg[3:0] % 4'h3);
			c = 2'(lfsr_reg[7:4] % 4'h3);
			exp_q.push_back({4'h1, r, c});
			press(kmask(r, c), 300);
		end
		settle(30000, 1'b1);
		// Chip disabled on-hook: the entry is ignored
		hook_switch_input <= 1'b1;
		ack_strap <= 1'b1;
		repeat (10) @(posedge sys_clk);
		press(kmask(2'h0, 2'h0), 300);
		ack_strap <= 1'b0;
		repeat (20) @(posedge sys_clk);
		// Scratchpad entry held long: one acknowledge, no signalling
		exp_q.push_back(8'h40);
		press(kmask(r, c), 600);
		settle(2000, 1'b1);
		// Pulse mode off-hook: digit two, both breaks dialed out
		mode_select <= 1'b0;
		hook_switch_input <= 1'b0;
		pre_exp = PRE_PULSE_TICKS * TCK;
		repeat (10) @(posedge sys_clk);
		exp_q.push_back(8'h40);
		exp_q.push_back(8'h80);
		exp_q.push_back(8'h80);
		press(kmask(2'h0, 2'h1), 300);
		settle(30000, 1'b0);
		// Modifier entered mid-dialing: acknowledged, never signalled
		exp_q.push_back(8'h40);
		press(kmask(2'h3, 2'h0), 300);
		check(16'(exp_q.size()), 16'h0);
		repeat (500 * TCK) @(posedge sys_clk);
		hook_switch_input <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check(16'(mute_oe_n), 16'h1);
		repeat (2000) @(posedge sys_clk);
		wrap_up();
	end
endmodule
